// [include/assp_pkg.sv]
// Shared constants and types of the audio serial slave port
package assp_pkg;
	// Serial format codes on serial_format_select
	localparam logic [1:0] FMT_I2S = 2'h0;
	localparam logic [1:0] FMT_LJ = 2'h1;
	localparam logic [1:0] FMT_RJ20 = 2'h2;
	localparam logic [1:0] FMT_RJ16 = 2'h3;
	// Half-frame lengths in bit clocks (32, 48 or 64 per frame)
	localparam logic [5:0] LEN_16 = 6'h10;
	localparam logic [5:0] LEN_24 = 6'h18;
	localparam logic [5:0] LEN_32 = 6'h20;
	localparam logic [5:0] CNT_MAX = 6'h3f;
	// Sample word widths
	localparam logic [5:0] WORD_16 = 6'h10;
	localparam logic [5:0] WORD_20 = 6'h14;
	localparam int SAMPLE_W = 20;
	localparam int PAIR_W = 40;
	localparam int RX_W = 21;
	// Master clock ratio code 3 is not a legal ratio
	localparam logic [1:0] RATIO_256 = 2'h0;
	localparam logic [1:0] RATIO_384 = 2'h1;
	localparam logic [1:0] RATIO_512 = 2'h2;
	localparam logic [1:0] RATIO_BAD = 2'h3;
	// Rate codes 0..8: 8, 11.025, 12, 16, 22.05, 24, 32, 44.1, 48 kHz
	localparam logic [3:0] RATE_MAX = 4'h8;
	localparam logic [3:0] RATE_11K025 = 4'h1;
	localparam logic [3:0] RATE_22K05 = 4'h4;
	localparam logic [3:0] RATE_44K1 = 4'h7;
	// Anti-pop unmute delay
	localparam int unsigned UNMUTE_DELAY_MS = 500;
	localparam int unsigned CLK_FREQ_HZ = 100000000;
	localparam int unsigned UNMUTE_CYCLES = UNMUTE_DELAY_MS * (CLK_FREQ_HZ / 1000);
	localparam int UNMUTE_CNT_W = 26;
	typedef enum logic [1:0] {CM_OFF, CM_RAMP, CM_ON} assp_cm_state_t;
endpackage

// [rtl/assp_fifo2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module assp_fifo2 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic v0_r;
	logic v1_r;
	logic [W-1:0] d0_r;
	logic [W-1:0] d1_r;
	logic rdy_r;
	logic push;
	logic pop;

	// Ready falls only when a push with no pop in the same cycle fills the second entry;
	// it is a flop of its own so the port is not behind an inverter
	assign push = in_valid && rdy_r;
	assign pop = v0_r && out_ready;
	assign in_ready = rdy_r;
	assign out_valid = v0_r;
	assign out_data = d0_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			v0_r <= 1'b0;
			v1_r <= 1'b0;
			rdy_r <= 1'b1;
			d0_r <= '0;
			d1_r <= '0;
		end else if (push && pop) begin
			if (v1_r) begin
				d0_r <= d1_r;
				d1_r <= in_data;
			end else begin
				d0_r <= in_data;
			end
		end else if (push) begin
			if (!v0_r) begin
				d0_r <= in_data;
				v0_r <= 1'b1;
			end else begin
				d1_r <= in_data;
				v1_r <= 1'b1;
				rdy_r <= 1'b0;
			end
		end else if (pop) begin
			d0_r <= d1_r;
			v0_r <= v1_r;
			v1_r <= 1'b0;
			rdy_r <= 1'b1;
		end
	end
endmodule

// [rtl/assp_audio_serial_slave_port.sv]
// Audio serial slave port with common-mode, keyclick and clock-setting checks
// Function
// - Configuration only on control ports, link carries samples
// - Link is slave; bit and frame clocks are inputs
// - Two-bit field selects one of four formats
// - Four wires: clocks, data in, data out
// - Accept 32, 48 or 64 clocks per frame
// - 32-clock frames force 16-bit words
// - Keyclick only while DAC or bypass enabled
// - Common-mode power has its own control bit
// - Keep audio muted about 500 ms after power-up
// - Master clock ratio 256, 384 or 512 declared
// - Playback and record share one rate, 8-48 kHz
`timescale 1ns/1ps
module assp_audio_serial_slave_port #(
	parameter int unsigned UNMUTE_CYCLES = assp_pkg::UNMUTE_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic bit_clock_input,
	input wire logic frame_clock_input,
	input wire logic audio_serial_in,
	output logic audio_serial_out,
	input wire logic [1:0] serial_format_select,
	input wire logic [1:0] mclk_ratio_sel,
	input wire logic [3:0] sample_rate_select,
	input wire logic common_mode_power_ctl,
	input wire logic keyclick_req,
	input wire logic dac_path_en,
	input wire logic bypass_path_en,
	output logic audio_common_mode_voltage_en,
	output logic audio_mute,
	output logic keyclick_gate,
	output logic ratio_ok,
	output logic rate_ok,
	output logic rate_family_441,
	output logic frame_len_err,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_left,
	output logic [19:0] rx_data,
	output logic rx_overrun,
	input wire logic rx_overrun_clr,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [19:0] tx_left,
	input wire logic [19:0] tx_right,
	output logic tx_underrun,
	input wire logic tx_underrun_clr
);
	localparam logic [assp_pkg::UNMUTE_CNT_W-1:0] UNMUTE_LAST =
		assp_pkg::UNMUTE_CNT_W'(UNMUTE_CYCLES - 1);

	// ---------------- Control side, mclk ----------------
	assp_pkg::assp_cm_state_t cm_state_r;
	logic [assp_pkg::UNMUTE_CNT_W-1:0] unmute_cnt_r;
	logic cm_en_r;
	logic mute_r;
	logic keyclick_r;
	logic ratio_ok_r;
	logic rate_ok_r;
	logic fam_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cm_state_r <= assp_pkg::CM_OFF;
			unmute_cnt_r <= '0;
		end else begin
			case (cm_state_r)
			assp_pkg::CM_OFF: begin
				if (common_mode_power_ctl) begin
					cm_state_r <= assp_pkg::CM_RAMP;
					unmute_cnt_r <= '0;
				end
			end
			assp_pkg::CM_RAMP: begin
				if (!common_mode_power_ctl) begin
					cm_state_r <= assp_pkg::CM_OFF;
				end else if (unmute_cnt_r == UNMUTE_LAST) begin
					cm_state_r <= assp_pkg::CM_ON;
				end else begin
					unmute_cnt_r <= unmute_cnt_r + 1'b1;
				end
			end
			assp_pkg::CM_ON: begin
				if (!common_mode_power_ctl) begin
					cm_state_r <= assp_pkg::CM_OFF;
				end
			end
			default: begin
				cm_state_r <= assp_pkg::CM_OFF;
			end
			endcase
		end
	end

	// Mute is lifted on the same edge the ramp state hands over to on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cm_en_r <= 1'b0;
			mute_r <= 1'b1;
		end else begin
			cm_en_r <= common_mode_power_ctl;
			mute_r <= !(common_mode_power_ctl &&
				(cm_state_r == assp_pkg::CM_ON ||
				(cm_state_r == assp_pkg::CM_RAMP && unmute_cnt_r == UNMUTE_LAST)));
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			keyclick_r <= 1'b0;
			ratio_ok_r <= 1'b0;
			rate_ok_r <= 1'b0;
			fam_r <= 1'b0;
		end else begin
			keyclick_r <= keyclick_req && (dac_path_en || bypass_path_en);
			ratio_ok_r <= mclk_ratio_sel != assp_pkg::RATIO_BAD;
			rate_ok_r <= sample_rate_select <= assp_pkg::RATE_MAX;
			fam_r <= sample_rate_select == assp_pkg::RATE_11K025 ||
				sample_rate_select == assp_pkg::RATE_22K05 ||
				sample_rate_select == assp_pkg::RATE_44K1;
		end
	end

	// ---------------- Link side, bit clock ----------------
	// The link clock is only ever an input here
	logic rst_b_meta_r;
	logic rst_b_n_r;
	logic [1:0] fmt_s1_r;
	logic [1:0] fmt_b_r;
	logic lr_r;
	logic started_r;
	logic [5:0] cnt_r;
	logic [5:0] half_len_r;
	logic [31:0] sh_r;
	logic frame_bad_r;
	logic [assp_pkg::RX_W-1:0] rx_hold_r;
	logic rx_tog_r;
	logic [assp_pkg::PAIR_W-1:0] tx_pair_r;
	logic [assp_pkg::PAIR_W-1:0] tx_hold_r;
	logic tx_req_r;
	logic out_bit_r;
	logic sout_r;
	logic edge_now;
	logic [5:0] cnt_nxt;
	logic w16_rx;
	logic w16_tx;
	logic [5:0] rx_w;
	logic [5:0] amt;
	logic [31:0] shifted;
	logic [19:0] cap_val;
	logic wrap;
	logic load;
	logic next_left;
	logic [6:0] q;
	logic [6:0] tx_w;
	logic [6:0] hl;
	logic [6:0] m;
	logic m_ok;
	logic [6:0] bit_idx;
	logic [assp_pkg::PAIR_W-1:0] src;
	logic [19:0] w20;
	logic out_bit_nxt;

	// Bit-clock reset: asserts at once, releases on a bit clock edge
	always_ff @(posedge bit_clock_input or negedge rst_n) begin
		if (!rst_n) begin
			rst_b_meta_r <= 1'b0;
			rst_b_n_r <= 1'b0;
		end else begin
			rst_b_meta_r <= 1'b1;
			rst_b_n_r <= rst_b_meta_r;
		end
	end

	// Format is quasi-static: host changes it only with the converters down
	always_ff @(posedge bit_clock_input or negedge rst_b_n_r) begin
		if (!rst_b_n_r) begin
			fmt_s1_r <= assp_pkg::FMT_I2S;
			fmt_b_r <= assp_pkg::FMT_I2S;
		end else begin
			fmt_s1_r <= serial_format_select;
			fmt_b_r <= fmt_s1_r;
		end
	end

	// Frame clock and data are synchronous to the bit clock
	assign edge_now = frame_clock_input != lr_r;
	assign cnt_nxt = edge_now ? 6'h01 :
		(cnt_r == assp_pkg::CNT_MAX ? cnt_r : cnt_r + 6'h01);

	always_comb begin
		w16_rx = fmt_b_r == assp_pkg::FMT_RJ16 || cnt_r == assp_pkg::LEN_16;
		rx_w = w16_rx ? assp_pkg::WORD_16 : assp_pkg::WORD_20;
		if (fmt_b_r == assp_pkg::FMT_LJ && cnt_r >= rx_w) begin
			amt = cnt_r - rx_w;
		end else if (fmt_b_r == assp_pkg::FMT_I2S && cnt_r > rx_w) begin
			amt = cnt_r - rx_w - 6'h01;
		end else begin
			amt = 6'h00;
		end
		shifted = sh_r >> amt;
		cap_val = w16_rx ? {shifted[15:0], 4'h0} : shifted[19:0];
	end

	always_ff @(posedge bit_clock_input or negedge rst_b_n_r) begin
		if (!rst_b_n_r) begin
			lr_r <= 1'b0;
			started_r <= 1'b0;
			cnt_r <= 6'h00;
			half_len_r <= 6'h00;
			sh_r <= 32'h0000_0000;
			frame_bad_r <= 1'b0;
			rx_hold_r <= '0;
			rx_tog_r <= 1'b0;
		end else begin
			lr_r <= frame_clock_input;
			sh_r <= {sh_r[30:0], audio_serial_in};
			cnt_r <= cnt_nxt;
			if (edge_now) begin
				started_r <= 1'b1;
				half_len_r <= cnt_r;
				if (started_r) begin
					frame_bad_r <= !(cnt_r == assp_pkg::LEN_16 ||
						cnt_r == assp_pkg::LEN_24 || cnt_r == assp_pkg::LEN_32);
					rx_hold_r <= {!lr_r, cap_val};
					rx_tog_r <= !rx_tog_r;
				end
			end
		end
	end

	// Output side predicts the next position from the last half length,
	// so the first bit of a half is already on the wire at its first rise
	always_comb begin
		w16_tx = fmt_b_r == assp_pkg::FMT_RJ16 || half_len_r == assp_pkg::LEN_16;
		tx_w = {1'b0, w16_tx ? assp_pkg::WORD_16 : assp_pkg::WORD_20};
		hl = {1'b0, half_len_r};
		wrap = started_r && cnt_nxt == half_len_r;
		load = wrap && frame_clock_input;
		next_left = wrap ? frame_clock_input : !frame_clock_input;
		q = wrap ? 7'h00 : {1'b0, cnt_nxt};
		if (fmt_b_r == assp_pkg::FMT_LJ) begin
			m = q;
			m_ok = q < tx_w;
		end else if (fmt_b_r == assp_pkg::FMT_I2S) begin
			m = q - 7'h01;
			m_ok = q != 7'h00 && q <= tx_w;
		end else begin
			m = q + tx_w - hl;
			m_ok = q + tx_w >= hl && q < hl;
		end
		bit_idx = 7'h13 - m;
		src = load ? tx_hold_r : tx_pair_r;
		w20 = next_left ? src[39:20] : src[19:0];
		out_bit_nxt = m_ok && w20[bit_idx[4:0]];
	end

	always_ff @(posedge bit_clock_input or negedge rst_b_n_r) begin
		if (!rst_b_n_r) begin
			tx_pair_r <= '0;
			tx_req_r <= 1'b0;
			out_bit_r <= 1'b0;
		end else begin
			out_bit_r <= out_bit_nxt;
			if (load) begin
				tx_pair_r <= tx_hold_r;
				tx_req_r <= !tx_req_r;
			end
		end
	end

	always_ff @(negedge bit_clock_input or negedge rst_b_n_r) begin
		if (!rst_b_n_r) begin
			sout_r <= 1'b0;
		end else begin
			sout_r <= out_bit_r;
		end
	end

	// ---------------- Crossings back to mclk ----------------
	logic rxt_s1_r;
	logic rxt_s2_r;
	logic rxt_s3_r;
	logic txq_s1_r;
	logic txq_s2_r;
	logic txq_s3_r;
	logic bad_s1_r;
	logic bad_s2_r;
	logic rx_evt;
	logic tx_evt;
	logic rx_in_ready;
	logic txf_valid;
	logic [assp_pkg::PAIR_W-1:0] txf_data;
	logic [assp_pkg::RX_W-1:0] rxf_data;
	logic rx_ovr_r;
	logic tx_und_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rxt_s1_r <= 1'b0;
			rxt_s2_r <= 1'b0;
			rxt_s3_r <= 1'b0;
			txq_s1_r <= 1'b0;
			txq_s2_r <= 1'b0;
			txq_s3_r <= 1'b0;
			bad_s1_r <= 1'b0;
			bad_s2_r <= 1'b0;
		end else begin
			rxt_s1_r <= rx_tog_r;
			rxt_s2_r <= rxt_s1_r;
			rxt_s3_r <= rxt_s2_r;
			txq_s1_r <= tx_req_r;
			txq_s2_r <= txq_s1_r;
			txq_s3_r <= txq_s2_r;
			bad_s1_r <= frame_bad_r;
			bad_s2_r <= bad_s1_r;
		end
	end

	// Held words are stable for a whole half-frame around each toggle
	assign rx_evt = rxt_s2_r ^ rxt_s3_r;
	assign tx_evt = txq_s2_r ^ txq_s3_r;

	assp_fifo2 #(.W(assp_pkg::RX_W)) u_rx_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.in_valid(rx_evt),
		.in_ready(rx_in_ready),
		.in_data(rx_hold_r),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rxf_data)
	);

	assp_fifo2 #(.W(assp_pkg::PAIR_W)) u_tx_fifo (
		.clk(mclk),
		.rst_n(rst_n),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data({tx_left, tx_right}),
		.out_valid(txf_valid),
		.out_ready(tx_evt),
		.out_data(txf_data)
	);

	// The link cannot be stalled, so a full buffer drops the word and flags it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_hold_r <= '0;
			rx_ovr_r <= 1'b0;
			tx_und_r <= 1'b0;
		end else begin
			if (tx_evt) begin
				tx_hold_r <= txf_valid ? txf_data : '0;
			end
			if (rx_evt && !rx_in_ready) begin
				rx_ovr_r <= 1'b1;
			end else if (rx_overrun_clr) begin
				rx_ovr_r <= 1'b0;
			end
			if (tx_evt && !txf_valid) begin
				tx_und_r <= 1'b1;
			end else if (tx_underrun_clr) begin
				tx_und_r <= 1'b0;
			end
		end
	end

	// Registers are reached only through the control ports
	assign audio_serial_out = sout_r;
	assign audio_common_mode_voltage_en = cm_en_r;
	assign audio_mute = mute_r;
	assign keyclick_gate = keyclick_r;
	assign ratio_ok = ratio_ok_r;
	assign rate_ok = rate_ok_r;
	assign rate_family_441 = fam_r;
	assign frame_len_err = bad_s2_r;
	assign rx_left = rxf_data[20];
	assign rx_data = rxf_data[19:0];
	assign rx_overrun = rx_ovr_r;
	assign tx_underrun = tx_und_r;

	// ---------------- Assertions ----------------
	property p_unmute_delay;
		@(posedge mclk) disable iff (!rst_n)
		$fell(mute_r) |-> $past(cm_state_r) == assp_pkg::CM_RAMP &&
			$past(unmute_cnt_r) == UNMUTE_LAST;
	endproperty
	a_unmute_delay: assert property (p_unmute_delay) else $error("unmute before delay");

	property p_mute_when_off;
		@(posedge mclk) disable iff (!rst_n)
		!cm_en_r |-> mute_r;
	endproperty
	a_mute_when_off: assert property (p_mute_when_off) else $error("unmuted while off");

	property p_keyclick;
		@(posedge mclk) disable iff (!rst_n)
		keyclick_r |-> $past(dac_path_en) || $past(bypass_path_en);
	endproperty
	a_keyclick: assert property (p_keyclick) else $error("keyclick with paths off");

	property p_ratio;
		@(posedge mclk) disable iff (!rst_n)
		mclk_ratio_sel == assp_pkg::RATIO_BAD |=> !ratio_ok_r;
	endproperty
	a_ratio: assert property (p_ratio) else $error("bad ratio accepted");

	property p_rate;
		@(posedge mclk) disable iff (!rst_n)
		sample_rate_select > assp_pkg::RATE_MAX |=> !rate_ok_r;
	endproperty
	a_rate: assert property (p_rate) else $error("bad rate accepted");

	property p_rx_push;
		@(posedge mclk) disable iff (!rst_n)
		rx_evt && rx_in_ready |=> rx_valid;
	endproperty
	a_rx_push: assert property (p_rx_push) else $error("received word lost");

	property p_tx_pop;
		@(posedge mclk) disable iff (!rst_n)
		tx_evt && txf_valid |=> tx_hold_r == $past(txf_data);
	endproperty
	a_tx_pop: assert property (p_tx_pop) else $error("transmit pair not loaded");

	property p_i2s_cap;
		@(posedge bit_clock_input) disable iff (!rst_b_n_r)
		edge_now && started_r && fmt_b_r == assp_pkg::FMT_I2S && cnt_r == assp_pkg::LEN_32
		|=> rx_hold_r[19:0] == $past(sh_r[30:11]);
	endproperty
	a_i2s_cap: assert property (p_i2s_cap) else $error("i2s word misaligned");

	property p_w16;
		@(posedge bit_clock_input) disable iff (!rst_b_n_r)
		edge_now && started_r && cnt_r == assp_pkg::LEN_16 |=> rx_hold_r[3:0] == 4'h0;
	endproperty
	a_w16: assert property (p_w16) else $error("wide word in short frame");

	property p_bad_len;
		@(posedge bit_clock_input) disable iff (!rst_b_n_r)
		edge_now && started_r && cnt_r == 6'h14 |=> frame_bad_r;
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad frame length not flagged");

	property p_out_fall;
		@(posedge bit_clock_input) disable iff (!rst_b_n_r)
		started_r |-> sout_r == out_bit_r;
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("output not updated on fall");

	c_unmute: cover property (@(posedge mclk) disable iff (!rst_n) $fell(mute_r));
	c_rx_push: cover property (@(posedge mclk) disable iff (!rst_n) rx_evt && rx_in_ready);
	c_tx_pop: cover property (@(posedge mclk) disable iff (!rst_n) tx_evt && txf_valid);
	c_overrun: cover property (@(posedge mclk) disable iff (!rst_n) $rose(rx_ovr_r));
endmodule

// [tb/assp_link_master.sv]
// Serial audio bus master model: bit and frame clocks, data to and from the port
`timescale 1ns/1ps
module assp_link_master (
	output logic bck,
	output logic lrck,
	output logic sdin,
	input wire logic sdout,
	output logic cap_tgl,
	output logic cap_lr,
	output logic [31:0] cap_bits,
	output logic [5:0] cap_n
);
	logic [31:0] sh;
	logic [5:0] cnt;
	logic lr_q;
	initial begin
		{bck, lrck, sdin, cap_tgl, cap_lr, lr_q} = 6'h0;
		cap_bits = 32'h0;
		cap_n = 6'h0;
		sh = 32'h0;
		cnt = 6'h0;
	end
	function automatic int start_pos(input logic [1:0] f, input int n, input int wd);
		return (f == 2'h0) ? 1 : (f == 2'h1) ? 0 : n - wd;
	endfunction
	// Port output is taken on the rise; a frame clock change closes the half
	always @(posedge bck) begin
		if (lrck !== lr_q) begin
			cap_lr <= lr_q;
			cap_bits <= sh;
			cap_n <= cnt;
			cap_tgl <= ~cap_tgl;
			sh <= {31'h0, sdout};
			cnt <= 6'h1;
		end else begin
			sh <= {sh[30:0], sdout};
			cnt <= cnt + 6'h1;
		end
		lr_q <= lrck;
	end
	// Master makes both clocks; data and frame clock move while the bit clock is low,
	// 40 ns either side of the rise, and the clock stands still between bursts
	task automatic send_half(input logic lr, input logic [19:0] w, input logic [1:0] f,
		input int n);
		int s;
		int wd;
		wd = (f == 2'h3 || n == 16) ? 16 : 20;
		s = start_pos(f, n, wd);
		for (int p = 0; p < n; p++) begin
			lrck = lr;
			sdin = (p >= s && p < s + wd) ? w[19 - (p - s)] : p[0];
			#40 bck = 1'b1;
			#40 bck = 1'b0;
		end
	endtask
	// After the closing bit the line is released and shows the inverse of its last bit
	task automatic release_line();
		sdin = ~sdin;
	endtask
endmodule

// [tb/assp_audio_serial_slave_port_tb.sv]
// Self-checking bench for the audio serial slave port
`timescale 1ns/1ps
module assp_audio_serial_slave_port_tb;
	localparam int UNM = 20;
	logic mclk, rst_n, bck, lrck, sdin, sdout, cap_tgl, cap_lr, tx_on, tx_took, tx_seen, rx_go;
	logic [1:0] fmt, ratio;
	logic [3:0] rate;
	logic cm_ctl, kc, dac_en, byp_en, cm_en, mute, kc_gate, ratio_ok, rate_ok, fam, len_err;
	logic rx_valid, rx_ready, rx_left, rx_ovr, rx_ovr_clr, tx_valid, tx_ready, tx_unr, tx_unr_clr;
	logic [19:0] rx_data, tx_l, tx_r, w;
	logic [31:0] cap_bits;
	logic [5:0] cap_n;
	logic [20:0] e, et;
	logic [20:0] rx_q[$];
	logic [20:0] tx_q[$];
	integer seed = 32'h46aa;
	int n_mismatch = 0;
	int total_checks = 0;
	int wd;
	int s;
	int cur_n = 0;

	assp_audio_serial_slave_port #(.UNMUTE_CYCLES(UNM)) dut (
		.mclk(mclk), .rst_n(rst_n), .bit_clock_input(bck), .frame_clock_input(lrck),
		.audio_serial_in(sdin), .audio_serial_out(sdout), .serial_format_select(fmt),
		.mclk_ratio_sel(ratio), .sample_rate_select(rate), .common_mode_power_ctl(cm_ctl),
		.keyclick_req(kc), .dac_path_en(dac_en), .bypass_path_en(byp_en),
		.audio_common_mode_voltage_en(cm_en), .audio_mute(mute), .keyclick_gate(kc_gate),
		.ratio_ok(ratio_ok), .rate_ok(rate_ok), .rate_family_441(fam), .frame_len_err(len_err),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_left(rx_left), .rx_data(rx_data),
		.rx_overrun(rx_ovr), .rx_overrun_clr(rx_ovr_clr), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_left(tx_l), .tx_right(tx_r), .tx_underrun(tx_unr),
		.tx_underrun_clr(tx_unr_clr)
	);
	assp_link_master lm (
		.bck(bck), .lrck(lrck), .sdin(sdin), .sdout(sdout), .cap_tgl(cap_tgl),
		.cap_lr(cap_lr), .cap_bits(cap_bits), .cap_n(cap_n)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Valid is only dropped once taken, or while reset clears the buffer
	always @(posedge mclk) tx_took <= tx_valid && tx_ready;
	always @(negedge mclk) begin
		rx_ready <= rx_go && ($random(seed) & 3) != 0;
		if (tx_took) begin
			tx_q.push_back({1'b1, tx_l});
			tx_q.push_back({1'b0, tx_r});
		end
		if (!tx_valid || tx_took || !rst_n) begin
			tx_l <= 20'h80000 | 20'($random(seed));
			tx_r <= 20'h80000 | 20'($random(seed));
			tx_valid <= tx_on;
		end
	end

	always @(posedge mclk) if (rst_n === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
		e = (rx_q.size() > 0) ? rx_q.pop_front() : 21'h0;
		check("rx word", {rx_left, rx_data}, e);
	end

	// Leading zero halves are underrun filler before the first pair goes out
	always @(cap_tgl) begin
		wd = (fmt == 2'h3 || cap_n == 6'h10) ? 16 : 20;
		s = lm.start_pos(fmt, int'(cap_n), wd);
		w = 20'h0;
		for (int i = 0; i < wd; i++) w[19 - i] = cap_bits[int'(cap_n) - 1 - s - i];
		// A half that spans a reset carries stale bits and a wrong length, so it is skipped
		if (rst_n === 1'b1 && int'(cap_n) == cur_n && (tx_seen || w != 20'h0)) begin
			tx_seen = 1'b1;
			et = (tx_q.size() > 0) ? tx_q.pop_front() : {~cap_lr, 20'h0};
			et[19:0] = et[19:0] & (wd == 16 ? 20'hffff0 : 20'hfffff);
			check("tx word", {~cap_lr, w}, et);
		end
	end

	task automatic do_reset();
		@(negedge mclk);
		rst_n = 1'b0;
		tx_on = 1'b0;
		rx_go = 1'b1;
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		repeat (2) @(negedge mclk);
		rx_q.delete();
		tx_q.delete();
		tx_seen = 1'b0;
	endtask

	task automatic run(input logic [1:0] f, input int n, input int nfr, input logic stall,
		input logic go);
		logic [19:0] l;
		logic [19:0] r;
		logic [19:0] m;
		fmt = f;
		cur_n = n;
		do_reset();
		rx_go = !stall;
		tx_on = go;
		m = (f == 2'h3 || n == 16) ? 20'hffff0 : 20'hfffff;
		repeat (20) @(negedge mclk);
		if (go) check("tx full", tx_ready, 0);
		// Keeps the bit clock edges off the system clock edges
		#3;
		for (int k = 0; k < nfr; k++) begin
			l = $random(seed);
			r = $random(seed);
			// First left half is discarded; a stalled reader keeps only two words
			if (k > 0 && (!stall || k == 1)) rx_q.push_back({1'b1, l & m});
			if (!stall || k == 0) rx_q.push_back({1'b0, r & m});
			lm.send_half(1'b0, l, f, n);
			lm.send_half(1'b1, r, f, n);
		end
		lm.send_half(1'b0, 20'h0, f, 1);
		lm.release_line();
		repeat (20) @(negedge mclk);
		rx_go = 1'b1;
		repeat (40) @(negedge mclk);
		check("rx pending", rx_q.size(), 0);
		check("len err", len_err, !(n == 16 || n == 24 || n == 32));
		check("overrun", rx_ovr, stall);
		check("underrun", tx_unr, !go);
		rx_ovr_clr = 1'b1;
		tx_unr_clr = 1'b1;
		@(negedge mclk);
		rx_ovr_clr = 1'b0;
		tx_unr_clr = 1'b0;
		@(negedge mclk);
		check("flags clear", {rx_ovr, tx_unr}, 0);
		$display("link test fmt %0d len %0d done", f, n);
	endtask

	initial begin
		{rst_n, cm_ctl, kc, dac_en, byp_en, rx_ready, rx_ovr_clr, tx_unr_clr} = 8'h0;
		{tx_valid, tx_on, rx_go, tx_seen} = 4'h0;
		{fmt, ratio, rate} = 8'h0;
		tx_l = 20'h0;
		tx_r = 20'h0;
		do_reset();
		for (int i = 0; i < 16; i++) begin
			rate = 4'(i);
			ratio = 2'(i >> 2);
			{kc, dac_en, byp_en} = 3'(i);
			repeat (2) @(negedge mclk);
			check("ratio ok", ratio_ok, ratio != 2'h3);
			check("rate ok", rate_ok, i <= 8);
			check("rate family", fam, i == 1 || i == 4 || i == 7);
			check("keyclick", kc_gate, kc && (dac_en || byp_en));
		end
		$display("control test done");
		cm_ctl = 1'b1;
		// Mute holds through the ramp and stays lifted while common mode is kept on
		for (int k = 1; k <= UNM + 6; k++) begin
			@(negedge mclk);
			if (k == 1) check("cm on", cm_en, 1);
			check("mute", mute, k <= UNM);
		end
		cm_ctl = 1'b0;
		@(negedge mclk);
		check("cm off", {cm_en, mute}, 1);
		$display("common mode test done");
		for (int f = 0; f < 4; f++) run(2'(f), 32, 4, 1'b0, 1'b1);
		run(2'h1, 24, 4, 1'b0, 1'b1);
		run(2'h1, 16, 4, 1'b0, 1'b1);
		run(2'h3, 16, 4, 1'b0, 1'b1);
		run(2'h1, 20, 3, 1'b0, 1'b0);
		run(2'h1, 32, 4, 1'b1, 1'b1);
		test_done();
	end

	initial begin
		#800000;
		n_mismatch++;
		test_done();
	end
endmodule
